//--- zcb_consts.vh
/*
 constants for the zero-compare branch unit: opcode fields, selector codes,
 condition kinds, one-hot states and widths.
 assumes 32-bit instruction words with the usual 6/5/5/16 field split.
*/
// What this block does
// - decode ge-zero likely under register-immediate group
// - decode le-zero from opcode 000110, rt 00000
// - offset shifted left two, sign extended
// - target is delay-slot address plus displacement
// - test full register, redirect next slot
// - ge-zero true when sign bit clear
// - gt-zero true when sign clear, nonzero
// - le-zero true when sign set or zero
// - taken: run delay slot, then target
// - likely not taken: squash delay slot
// - likely variants statically predicted taken
// - oldest level: likely raises reserved instruction
`ifndef ZCB_CONSTS_VH
`define ZCB_CONSTS_VH

// instruction fields
`define ZCB_OPC_HI 31
`define ZCB_OPC_LO 26
`define ZCB_SRC_HI 25
`define ZCB_SRC_LO 21
`define ZCB_SEL_HI 20
`define ZCB_SEL_LO 16
`define ZCB_OFF_HI 15
`define ZCB_OFF_LO 0

// primary opcodes and selectors
`define ZCB_OPC_REG_IMM 6'h01
`define ZCB_OPC_LE_ZERO 6'h06
`define ZCB_SEL_ZERO 5'h00

// displacement shape
`define ZCB_OFF_W 16
`define ZCB_DISP_SHIFT 2
`define ZCB_DISP_W 18
`define ZCB_SLOT_STEP 3'h4
`define ZCB_SLOT_STEP_W 3

// condition kinds
`define ZCB_KIND_GE 2'h0
`define ZCB_KIND_GT 2'h1
`define ZCB_KIND_LE 2'h2

// one-hot states
`define ZCB_ST_IDLE 2'h1
`define ZCB_ST_SLOT 2'h2

`endif

//--- zcb_cond.v
/*
 zero-compare condition evaluator for one register value.
 assumes kind codes from zcb_consts.vh; purely combinational.
*/
`timescale 1ns/1ps
`include "zcb_consts.vh"

module zcb_cond #(
    parameter REG_W = 64
) (
    // operand
    input wire [REG_W-1:0] value,
    input wire [1:0] kind,
    // result
    output reg cond
);

    wire sign;
    wire is_zero;

    assign sign = value[REG_W-1];
    assign is_zero = ~|value;

    always @* begin
        cond = 1'b0;
        if (kind == `ZCB_KIND_GE) begin
            cond = ~sign;
        end else if (kind == `ZCB_KIND_GT) begin
            cond = ~sign & ~is_zero;
        end else if (kind == `ZCB_KIND_LE) begin
            cond = sign | is_zero;
        end
    end

endmodule // zcb_cond

//--- zcb_branch_unit.v
/*
 zero-compare branch unit: decodes five conditional branches, evaluates
 them, forms the target and steers the delay slot.
 assumes issue is in program order, one instruction per cycle with issue_valid high,
 and the register value for the source field arrives in the issue cycle.
*/
`timescale 1ns/1ps
`include "zcb_consts.vh"

module zcb_branch_unit #(
    parameter ADDR_W = 64,
    parameter REG_W = 64,
    parameter [5:0] OPC_GT_ZERO = 6'h07,
    parameter [5:0] OPC_GT_ZERO_LIKELY = 6'h17,
    parameter [5:0] OPC_LE_ZERO_LIKELY = 6'h16,
    parameter [4:0] SEL_GE_ZERO_LIKELY = 5'h03
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_b,
    // issue stage
    input wire issue_valid,
    input wire [31:0] issue_instr,
    input wire [ADDR_W-1:0] issue_pc,
    input wire legacy_isa,
    // register file read
    output wire [4:0] source_register_field,
    input wire [REG_W-1:0] src_value,
    // decode results
    output wire is_branch,
    output wire predict_taken,
    output wire reserved_instr,
    // delay slot outcome
    output wire redirect_valid,
    output reg [ADDR_W-1:0] redirect_pc,
    output wire squash_delay_slot,
    output wire mispredict,
    // last branch record
    output reg last_taken,
    output reg [ADDR_W-1:0] last_target
);

    // field extraction
    wire [5:0] opc;
    wire [4:0] sel;
    wire [15:0] off;

    assign opc = issue_instr[`ZCB_OPC_HI:`ZCB_OPC_LO];
    assign sel = issue_instr[`ZCB_SEL_HI:`ZCB_SEL_LO];
    assign off = issue_instr[`ZCB_OFF_HI:`ZCB_OFF_LO];
    assign source_register_field = issue_instr[`ZCB_SRC_HI:`ZCB_SRC_LO];

    // decode
    reg dec_hit;
    reg dec_likely;
    reg [1:0] dec_kind;

    always @* begin
        dec_hit = 1'b0;
        dec_likely = 1'b0;
        dec_kind = `ZCB_KIND_GE;
        if (opc == `ZCB_OPC_REG_IMM && sel == SEL_GE_ZERO_LIKELY) begin
            dec_hit = 1'b1;
            dec_likely = 1'b1;
            dec_kind = `ZCB_KIND_GE;
        end else if (opc == OPC_GT_ZERO && sel == `ZCB_SEL_ZERO) begin
            dec_hit = 1'b1;
            dec_kind = `ZCB_KIND_GT;
        end else if (opc == OPC_GT_ZERO_LIKELY && sel == `ZCB_SEL_ZERO) begin
            dec_hit = 1'b1;
            dec_likely = 1'b1;
            dec_kind = `ZCB_KIND_GT;
        end else if (opc == `ZCB_OPC_LE_ZERO && sel == `ZCB_SEL_ZERO) begin
            dec_hit = 1'b1;
            dec_kind = `ZCB_KIND_LE;
        end else if (opc == OPC_LE_ZERO_LIKELY && sel == `ZCB_SEL_ZERO) begin
            dec_hit = 1'b1;
            dec_likely = 1'b1;
            dec_kind = `ZCB_KIND_LE;
        end
    end

    // state
    localparam [1:0] ST_IDLE = `ZCB_ST_IDLE;
    localparam [1:0] ST_SLOT = `ZCB_ST_SLOT;

    reg [1:0] state;
    reg [1:0] next_state;
    reg pend_taken;
    reg pend_squash;
    reg pend_likely;

    // decode while idle only; a branch in a slot is not defined
    wire in_idle;
    wire accept;
    wire blocked;
    wire slot_issue;

    assign in_idle = (state == ST_IDLE);
    assign blocked = dec_likely & legacy_isa;
    assign accept = issue_valid & in_idle & dec_hit & ~blocked;
    assign slot_issue = issue_valid & (state == ST_SLOT);

    assign is_branch = accept;
    assign predict_taken = accept & dec_likely;
    assign reserved_instr = issue_valid & in_idle & dec_hit & blocked;

    // condition on the full register
    wire cond;

    zcb_cond #(
        .REG_W(REG_W)
    ) u_cond (
        .value(src_value),
        .kind(dec_kind),
        .cond(cond)
    );

    // target from delay-slot address
    wire [ADDR_W-1:0] step;
    wire [ADDR_W-1:0] disp;
    wire [ADDR_W-1:0] slot_pc;
    wire [ADDR_W-1:0] target;
    wire [ADDR_W-1:0] fall_pc;

    assign step = {{(ADDR_W-`ZCB_SLOT_STEP_W){1'b0}}, `ZCB_SLOT_STEP};
    assign disp = {{(ADDR_W-`ZCB_DISP_W){off[`ZCB_OFF_W-1]}}, off, {`ZCB_DISP_SHIFT{1'b0}}};
    assign slot_pc = issue_pc + step;
    assign target = slot_pc + disp;
    assign fall_pc = slot_pc + step;

    // next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state = ST_SLOT;
                end
            end
            ST_SLOT: begin
                if (issue_valid) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // outcome held for the delay slot
    reg next_pend_taken;
    reg next_pend_squash;
    reg next_pend_likely;
    reg [ADDR_W-1:0] next_redirect_pc;

    always @* begin
        next_pend_taken = pend_taken;
        next_pend_squash = pend_squash;
        next_pend_likely = pend_likely;
        next_redirect_pc = redirect_pc;
        if (accept) begin
            next_pend_taken = cond;
            next_pend_squash = dec_likely & ~cond;
            next_pend_likely = dec_likely;
            if (cond) begin
                next_redirect_pc = target;
            end else begin
                next_redirect_pc = fall_pc;
            end
        end else if (slot_issue) begin
            next_pend_taken = 1'b0;
            next_pend_squash = 1'b0;
            next_pend_likely = 1'b0;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pend_taken <= 1'b0;
            pend_squash <= 1'b0;
            pend_likely <= 1'b0;
            redirect_pc <= {ADDR_W{1'b0}};
        end else begin
            pend_taken <= next_pend_taken;
            pend_squash <= next_pend_squash;
            pend_likely <= next_pend_likely;
            redirect_pc <= next_redirect_pc;
        end
    end

    // last branch record
    reg next_last_taken;
    reg [ADDR_W-1:0] next_last_target;

    always @* begin
        next_last_taken = last_taken;
        next_last_target = last_target;
        if (accept) begin
            next_last_taken = cond;
            next_last_target = target;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            last_taken <= 1'b0;
            last_target <= {ADDR_W{1'b0}};
        end else begin
            last_taken <= next_last_taken;
            last_target <= next_last_target;
        end
    end

    // slot handling: redirect after the slot instruction issues
    assign redirect_valid = slot_issue & pend_taken;
    assign squash_delay_slot = slot_issue & pend_squash;
    assign mispredict = slot_issue & pend_likely & ~pend_taken;

endmodule // zcb_branch_unit

//--- zcb_branch_unit_asserts.sv
/* port checker for zcb_branch_unit.
 assumes 64-bit widths and the default opcode parameters. */
`timescale 1ns/1ps
module zcb_branch_unit_asserts (
    // clock and reset
    input wire clk_sys,
    input wire rst_b,
    // issue side
    input wire issue_valid,
    input wire [31:0] issue_instr,
    input wire [63:0] issue_pc,
    input wire legacy_isa,
    input wire [63:0] src_value,
    // outcomes
    input wire is_branch,
    input wire predict_taken,
    input wire reserved_instr,
    input wire redirect_valid,
    input wire [63:0] redirect_pc,
    input wire squash_delay_slot,
    input wire mispredict,
    input wire last_taken,
    input wire [63:0] last_target
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    wire [5:0] opc = issue_instr[31:26];
    wire src_sign = src_value[63];
    wire src_zero = src_value == 64'h0;
    wire [63:0] want_target = issue_pc + 64'h4 + {{46{issue_instr[15]}}, issue_instr[15:0], 2'b00};
    sequence s_taken;
        is_branch ##1 last_taken && issue_valid;
    endsequence
    sequence s_fall;
        is_branch && !predict_taken ##1 !last_taken && issue_valid;
    endsequence
    property p_ge;
        is_branch && opc == 6'h01 |=> last_taken == !$past(src_sign);
    endproperty
    a_ge: assert property (p_ge) else $error("ge condition wrong");
    property p_gt;
        is_branch && opc[3:0] == 4'h7 |=> last_taken == (!$past(src_sign) && !$past(src_zero));
    endproperty
    a_gt: assert property (p_gt) else $error("gt condition wrong");
    property p_le;
        is_branch && opc[3:0] == 4'h6 |=> last_taken == ($past(src_sign) || $past(src_zero));
    endproperty
    a_le: assert property (p_le) else $error("le condition wrong");
    property p_tgt;
        is_branch |=> last_target == $past(want_target);
    endproperty
    a_tgt: assert property (p_tgt) else $error("target wrong");
    property p_take;
        s_taken |-> redirect_valid && redirect_pc == last_target && !squash_delay_slot;
    endproperty
    a_take: assert property (p_take) else $error("taken slot wrong");
    property p_fall;
        s_fall |-> !redirect_valid && !squash_delay_slot;
    endproperty
    a_fall: assert property (p_fall) else $error("slot not run");
    property p_sq;
        squash_delay_slot |-> mispredict && !redirect_valid && !last_taken;
    endproperty
    a_sq: assert property (p_sq) else $error("squash wrong");
    property p_rsv;
        reserved_instr |-> legacy_isa && !is_branch && !predict_taken;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved wrong");
    property p_lik;
        is_branch && (opc == 6'h01 || opc[4]) |-> predict_taken && !reserved_instr;
    endproperty
    a_lik: assert property (p_lik) else $error("likely not predicted");
endmodule // zcb_branch_unit_asserts
bind zcb_branch_unit zcb_branch_unit_asserts i_chk (.clk_sys, .rst_b, .issue_valid, .issue_instr, .issue_pc,
    .legacy_isa, .src_value, .is_branch, .predict_taken, .reserved_instr, .redirect_valid, .redirect_pc,
    .squash_delay_slot, .mispredict, .last_taken, .last_target);

//--- zcb_branch_unit_tb_top.sv
/* bench for zcb_branch_unit: random branches of all five kinds.
 assumes 64-bit widths and the default opcode parameters. */
`timescale 1ns/1ps
module zcb_branch_unit_tb_top;
    localparam [29:0] OPCS = {6'h16, 6'h06, 6'h17, 6'h07, 6'h01};
    reg clk_sys = 0, rst_b = 0, issue_valid = 0, legacy_isa = 0, in_slot = 0, cnd, lk;
    reg [31:0] issue_instr = 0;
    reg [63:0] issue_pc = 0, src_value = 0, pc, v;
    reg [65:0] note_q[$];
    reg [65:0] note;
    reg [15:0] off;
    reg [4:0] src_sel;
    integer seed = 22, miscompares = 0, samples_checked = 0, n;
    wire is_branch, predict_taken, reserved_instr, redirect_valid, squash_delay_slot, mispredict;
    wire [4:0] source_register_field;
    wire [63:0] redirect_pc;
    zcb_branch_unit i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .issue_pc(issue_pc), .legacy_isa(legacy_isa),
        .source_register_field(source_register_field),
        .src_value(src_value), .is_branch(is_branch), .predict_taken(predict_taken),
        .reserved_instr(reserved_instr), .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
        .squash_delay_slot(squash_delay_slot), .mispredict(mispredict), .last_taken(), .last_target());
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task check(input [65:0] seen, input [65:0] want);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== want) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %0t seen %h want %h", $time, seen, want);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // branch of kind kd, then its slot
    task branch(input integer kd, input leg);
        begin
            lk = kd % 2 == 0; // even kinds are the likely forms
            cnd = kd == 0 ? !v[63] : kd < 3 ? !v[63] && v != 0 : v[63] || v == 0;
            @(posedge clk_sys) #1;
            issue_valid = 1;
            legacy_isa = leg;
            src_value = v;
            issue_pc = pc;
            issue_instr = {OPCS[kd*6 +: 6], src_sel, kd == 0 ? 5'h03 : 5'h00, off};
            #18 check({is_branch, predict_taken, reserved_instr}, leg && lk ? 3'b001 : {1'b1, lk, 1'b0});
            check(source_register_field, src_sel);
            if (!(leg && lk))
                note_q.push_back(cnd ? {2'b10, pc + 64'h4 + {{46{off[15]}}, off, 2'b00}} : {1'b0, lk, pc + 64'h8});
            @(posedge clk_sys) #1;
            in_slot = !(leg && lk);
            issue_instr = 32'h0;
            issue_pc = pc + 64'h4;
            src_value = ~v;
            @(posedge clk_sys) #1;
            issue_valid = 0;
            in_slot = 0;
        end
    endtask
    // slot outcome against oldest note
    always @(negedge clk_sys) begin
        if (in_slot) begin
            note = note_q.pop_front();
            check({redirect_valid, squash_delay_slot, redirect_pc}, note);
            check(mispredict, note[64]);
        end
    end
    initial begin
        #100000;
        miscompares = miscompares + 1;
        conclude;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        #1 rst_b = 1;
        for (n = 0; n < 300; n = n + 1) begin
            v = n < 20 ? 64'h0 : n < 40 ? 64'h1 : {$random(seed), $random(seed)};
            off = $random(seed);
            src_sel = $random(seed);
            pc = {$random(seed), $random(seed)} & ~64'h3;
            branch(n % 5, n % 7 == 3);
        end
        $display("random branch test done");
        conclude;
    end
endmodule // zcb_branch_unit_tb_top
